//--- dv/amd_ctl_diag_bench.sv
// Self-checking bench of the amplifier control and load diagnostic block
module amd_ctl_diag_bench;
  timeunit 1ns;
  timeprecision 100ps;
  // Waits scaled far down from milliseconds to keep the run short
  localparam int CHG_CYC = 40;
  localparam int SET_CYC = 60;
  localparam int MUT_CYC = 20;
  localparam int DIA_CYC = 20;
  localparam int LIMIT   = 4000;

  logic                         mclk, rst, en_pin, mute_addr_pin, ctl_wr_done, status_rd;
  logic                         charge_pump_on, input_charge_on, short_thresh_raised;
  logic                         load_thresh_200, drain_on;
  logic [3:0]                   out_above_ref, out_pos_high, overcurrent_det;
  logic [3:0]                   neg_low_side_on, ch_latched_off;
  logic [7:0]                   wr_addr;
  amd_pkg::amd_ctl_type         ctl_wdata, ctl_q, c;
  amd_pkg::amd_status_type      status_q;
  amd_pkg::amd_pwr_type         pwr_state;
  amd_pkg::amd_drive_type [1:0] pair_drive;
  int                           errors = 0;
  int                           checked = 0;
  int                           cycles = 0;

  amd_ctl_diag DUT (.mclk, .rst, .en_pin, .mute_addr_pin, .ctl_wr_done, .ctl_wdata, .status_rd,
    .out_above_ref, .out_pos_high, .overcurrent_det, .ctl_q, .status_q, .wr_addr, .pwr_state,
    .charge_pump_on, .input_charge_on, .short_thresh_raised, .load_thresh_200, .drain_on,
    .pair_drive, .neg_low_side_on, .ch_latched_off);
  amd_host_model host (.mclk, .ctl_wdata, .en_pin, .mute_addr_pin, .ctl_wr_done, .status_rd);

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      test_done();
    end
  end

  function automatic amd_pkg::amd_ctl_type dflt();
    amd_pkg::amd_ctl_type d;
    d = '0;
    d.addr_default_flag   = 1'b1;
    d.short_threshold_sel = 1'b1;
    d.standby_ctl         = 1'b1;
    return d;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic t_addr();
    check("rst", ctl_q, dflt());
    check("rstpwr", pwr_state, amd_pkg::AMD_PWR_OFF);
    host.power_up(1'b1);
    check("pin1", wr_addr, 8'hDA);
    host.power_down();
    host.power_up(1'b0);
    check("pin0", wr_addr, 8'hD8);
    for (int s = 0; s < 4; s++) begin
      c.addr_default_flag = 1'b1;
      c.addr_sel = 2'(s);
      host.write(c);
      check("dflt", wr_addr, 8'hD8);
      c.addr_default_flag = 1'b0;
      host.write(c);
      check("sel", wr_addr, 8'hD8 + 8'(s * 2));
    end
  endtask

  task automatic t_start();
    logic [1:0] code [3];
    code = '{2'h0, 2'h1, 2'h3};
    c.short_threshold_sel = 1'b0;
    host.write(c);
    check("thr", short_thresh_raised, 1'b1);
    c.standby_ctl = 1'b0;
    host.write(c);
    check("pwr", pwr_state, amd_pkg::AMD_PWR_ACTIVE);
    check("pump", charge_pump_on, 1'b1);
    c.input_charge_en = 1'b1;
    c.ch01_output_mode = 2'h2;
    c.ch23_output_mode = 2'h2;
    host.write(c);
    check("pre", pair_drive, 4'hA);
    check("ichg", input_charge_on, 1'b1);
    repeat (CHG_CYC) @(posedge mclk);
    c.input_charge_en = 1'b0;
    host.write(c);
    check("ichg", input_charge_on, 1'b0);
    repeat (SET_CYC) @(posedge mclk);
    for (int i = 0; i < 3; i++) begin
      c.ch01_output_mode = code[i];
      c.ch23_output_mode = code[(i + 1) % 3];
      host.write(c);
      check("mode", pair_drive, {code[(i + 1) % 3], code[i]});
    end
    c.ch23_output_mode = 2'h3;
    host.write(c);
    check("play", pair_drive, 4'hF);
    c.short_threshold_sel = 1'b1;
    host.write(c);
    check("thr", short_thresh_raised, 1'b0);
  endtask

  task automatic t_fault();
    @(posedge mclk) #1 overcurrent_det = 4'h4;
    @(posedge mclk) #1 overcurrent_det = 4'h0;
    repeat (2) @(posedge mclk);
    #1 check("latch", ch_latched_off, 4'h4);
    host.read();
    check("oc", status_q.overcurrent_flags, 4'hB);
    c.ch01_output_mode = 2'h1;
    c.ch23_output_mode = 2'h1;
    host.write(c);
    check("mute", pair_drive, 4'h5);
    repeat (MUT_CYC) @(posedge mclk);
    c.ch01_output_mode = 2'h0;
    c.ch23_output_mode = 2'h0;
    host.write(c);
    check("tri", pair_drive, 4'h0);
    c.standby_ctl = 1'b1;
    host.write(c);
    check("standby_ctl", pwr_state, amd_pkg::AMD_PWR_STANDBY);
    check("unlatch", ch_latched_off, 4'h0);
  endtask

  task automatic t_short();
    out_above_ref = 4'h5;
    c.short_diag_en = 1'b1;
    host.write(c);
    repeat (DIA_CYC) @(posedge mclk);
    host.read();
    check("batt", status_q.short_batt_flags, 4'h5);
    c.short_diag_en = 1'b0;
    host.write(c);
    c.standby_ctl = 1'b0;
    host.write(c);
    out_above_ref = 4'h6;
    c.short_diag_en = 1'b1;
    host.write(c);
    repeat (DIA_CYC) @(posedge mclk);
    host.read();
    check("gnd", status_q.short_ground_flags, 4'h9);
    check("batt", status_q.short_batt_flags, 4'h6);
    out_above_ref = 4'hF;
    repeat (2) @(posedge mclk);
    #1 check("hold", status_q.short_batt_flags, 4'h6);
    c.short_diag_en = 1'b0;
    host.write(c);
    host.read();
    check("live", status_q, 16'h000F);
  endtask

  task automatic t_open();
    c.load_threshold_sel = 1'b1;
    c.output_drain_to_ground = 1'b1;
    host.write(c);
    check("drain", drain_on, 1'b1);
    check("thr200", load_thresh_200, 1'b1);
    repeat (DIA_CYC) @(posedge mclk);
    c.output_drain_to_ground = 1'b0;
    c.open_load_diag_en = 1'b1;
    host.write(c);
    check("lowside", neg_low_side_on, 4'hF);
    out_pos_high = 4'h3;
    repeat (DIA_CYC) @(posedge mclk);
    host.read();
    check("oc", status_q.overcurrent_flags, 4'hF);
    check("load_ok_flags", status_q.load_ok_flags, 4'hC);
    c.open_load_diag_en = 1'b0;
    c.load_threshold_sel = 1'b0;
    host.write(c);
    check("lowside", neg_low_side_on, 4'h0);
    check("thr70", load_thresh_200, 1'b0);
  endtask

  task automatic t_off();
    c.standby_ctl = 1'b1;
    host.write(c);
    host.power_down();
    check("off", pwr_state, amd_pkg::AMD_PWR_OFF);
    c.standby_ctl = 1'b0;
    host.write(c);
    check("refused", ctl_q, dflt());
  endtask

  initial begin
    rst = 1'b1;
    out_above_ref = 4'h0;
    out_pos_high = 4'h0;
    overcurrent_det = 4'h0;
    c = dflt();
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    t_addr();
    t_start();
    t_fault();
    t_short();
    t_open();
    t_off();
    test_done();
  end
endmodule

//--- dv/amd_host_model.sv
// Host controller model: enable and address pins, control writes, status reads
module amd_host_model (
  input  wire logic            mclk,
  output amd_pkg::amd_ctl_type ctl_wdata,
  output logic                 en_pin,
  output logic                 mute_addr_pin,
  output logic                 ctl_wr_done,
  output logic                 status_rd
);
  timeunit 1ns;
  timeprecision 100ps;

  // Address pin idles released at its pull-up level
  initial begin
    en_pin        = 1'b0;
    mute_addr_pin = 1'b1;
    ctl_wr_done   = 1'b0;
    status_rd     = 1'b0;
    ctl_wdata     = '0;
  end

  task automatic power_up(input logic lsb);
    @(posedge mclk) #1 mute_addr_pin = lsb;
    @(posedge mclk) #1 en_pin = 1'b1;
    repeat (2) @(posedge mclk);
    #1 mute_addr_pin = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic power_down();
    @(posedge mclk) #1 en_pin = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // Data is inverted once released so a stale word never looks valid
  task automatic write(input amd_pkg::amd_ctl_type c);
    @(posedge mclk) #1 ctl_wdata = c;
    ctl_wr_done = 1'b1;
    @(posedge mclk) #1 ctl_wr_done = 1'b0;
    ctl_wdata = ~c;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic read();
    @(posedge mclk) #1 status_rd = 1'b1;
    @(posedge mclk) #1 status_rd = 1'b0;
  endtask
endmodule

//--- src/amd_ctl_diag.sv
// Mode sequencing, address selection and load diagnostics of a four-channel amplifier
//
// Overview of operation
// - Default flag set: address LSB from pin
// - Flag cleared: address from two-bit select
// - Standby bit 0 enables device, 1 standby
// - Mode code 10 precharges pair outputs
// - Codes 00 three-state, 01 mute, 11 play
// - Short flags live only while enabled
// - Two short flags per channel: battery and ground
// - Above reference battery, below ground
// - Shorts never block power-up; overcurrent latches
// - Open-load reports per-channel load-OK flags
// - Open-load: only negative low sides on
// - Load threshold select picks 70 or 200
`include "amd_regs.svh"

module amd_ctl_diag #(
  parameter int NUM_CH = 4
) (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    en_pin,
  input  wire logic                    mute_addr_pin,
  input  wire logic                    ctl_wr_done,
  input  wire amd_pkg::amd_ctl_type    ctl_wdata,
  input  wire logic                    status_rd,
  input  wire logic [NUM_CH-1:0]       out_above_ref,
  input  wire logic [NUM_CH-1:0]       out_pos_high,
  input  wire logic [NUM_CH-1:0]       overcurrent_det,
  output amd_pkg::amd_ctl_type         ctl_q,
  output amd_pkg::amd_status_type      status_q,
  output logic [7:0]                   wr_addr,
  output amd_pkg::amd_pwr_type         pwr_state,
  output logic                         charge_pump_on,
  output logic                         input_charge_on,
  output logic                         short_thresh_raised,
  output logic                         load_thresh_200,
  output logic                         drain_on,
  output amd_pkg::amd_drive_type [1:0] pair_drive,
  output logic [NUM_CH-1:0]            neg_low_side_on,
  output logic [NUM_CH-1:0]            ch_latched_off
);

  if (NUM_CH != 4) begin : g_bad_ch
    $error("amd_ctl_diag serves exactly four channels");
  end

  localparam amd_pkg::amd_ctl_type CTL_RST = '{
    addr_default_flag:      `AMD_RST_ADDR_DEFAULT,
    addr_sel:               `AMD_RST_ADDR_SEL,
    short_threshold_sel:    `AMD_RST_SHORT_THR,
    standby_ctl:            `AMD_RST_STANDBY,
    input_charge_en:        `AMD_RST_CHARGE,
    ch01_output_mode:       `AMD_RST_MODE,
    ch23_output_mode:       `AMD_RST_MODE,
    short_diag_en:          `AMD_RST_DIAG,
    output_drain_to_ground: `AMD_RST_DIAG,
    open_load_diag_en:      `AMD_RST_DIAG,
    load_threshold_sel:     `AMD_RST_LOAD_THR
  };

  // ----------------------------------------------------------------
  // Control state, address and power mode
  // ----------------------------------------------------------------
  amd_pkg::amd_ctl_type    ctl_r,     ctl_nxt;
  amd_pkg::amd_status_type stat_r,    stat_nxt;
  amd_pkg::amd_pwr_type    pwr_r,     pwr_nxt;
  amd_pkg::amd_drive_type [1:0] drv_r, drv_nxt;
  logic                    en_d_r,    en_d_nxt;
  logic                    lsb_r,     lsb_nxt;
  logic [7:0]              addr_r,    addr_nxt;
  logic [NUM_CH-1:0]       off_r,     off_nxt;
  logic [NUM_CH-1:0]       nlow_r,    nlow_nxt;
  logic [1:0]              addr_idx;
  logic                    diag_busy;
  amd_pkg::amd_status_type live;

  always_comb begin
    ctl_nxt = ctl_r;
    if (!en_pin) begin
      ctl_nxt = CTL_RST;
    end else if (ctl_wr_done) begin
      ctl_nxt = ctl_wdata;
    end
    en_d_nxt = en_pin;
    // Pin is released after enable rises, so catch it on that edge
    lsb_nxt = (en_pin && !en_d_r) ? mute_addr_pin : lsb_r;
    addr_idx = ctl_r.addr_default_flag ? {1'b0, lsb_r} : ctl_r.addr_sel;
    addr_nxt = `AMD_ADDR_BASE | {5'h00, addr_idx, 1'b0};
    if (!en_pin) begin
      pwr_nxt = amd_pkg::AMD_PWR_OFF;
    end else if (ctl_r.standby_ctl) begin
      pwr_nxt = amd_pkg::AMD_PWR_STANDBY;
    end else begin
      pwr_nxt = amd_pkg::AMD_PWR_ACTIVE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_r  <= CTL_RST;
      en_d_r <= 1'b0;
      lsb_r  <= 1'b0;
      addr_r <= `AMD_ADDR_BASE;
      pwr_r  <= amd_pkg::AMD_PWR_OFF;
    end else begin
      ctl_r  <= ctl_nxt;
      en_d_r <= en_d_nxt;
      lsb_r  <= lsb_nxt;
      addr_r <= addr_nxt;
      pwr_r  <= pwr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output drive per channel pair
  // ----------------------------------------------------------------
  // Any diagnostic or the drain forces three-state so no switch fights it
  assign diag_busy = ctl_r.short_diag_en | ctl_r.open_load_diag_en
                   | ctl_r.output_drain_to_ground;

  for (genvar p = 0; p < 2; p++) begin : g_pair
    logic [1:0] code;
    assign code = (p == 0) ? ctl_r.ch01_output_mode : ctl_r.ch23_output_mode;
    always_comb begin
      if (pwr_r != amd_pkg::AMD_PWR_ACTIVE || diag_busy) begin
        drv_nxt[p] = amd_pkg::AMD_DRV_TRISTATE;
      end else begin
        case (code)
          `AMD_MODE_TRISTATE:  drv_nxt[p] = amd_pkg::AMD_DRV_TRISTATE;
          `AMD_MODE_MUTE:      drv_nxt[p] = amd_pkg::AMD_DRV_MUTE;
          `AMD_MODE_PRECHARGE: drv_nxt[p] = amd_pkg::AMD_DRV_PRECHARGE;
          `AMD_MODE_PLAY:      drv_nxt[p] = amd_pkg::AMD_DRV_PLAY;
          default:             drv_nxt[p] = amd_pkg::AMD_DRV_TRISTATE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Diagnostics and overcurrent latch per channel
  // ----------------------------------------------------------------
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    always_comb begin
      // No short latch exists, so power-up is never held off
      off_nxt[c] = (pwr_r == amd_pkg::AMD_PWR_ACTIVE)
                 && (off_r[c] || (overcurrent_det[c]
                 && drv_r[c/2] != amd_pkg::AMD_DRV_TRISTATE));
      nlow_nxt[c] = ctl_r.open_load_diag_en;
      live.short_batt_flags[c]   = ctl_r.short_diag_en & out_above_ref[c];
      live.short_ground_flags[c] = ctl_r.short_diag_en & ~out_above_ref[c];
      live.load_ok_flags[c]      = ctl_r.open_load_diag_en & ~out_pos_high[c];
      live.overcurrent_flags[c]  = ~(off_r[c] | overcurrent_det[c]);
    end
  end

  always_comb begin
    stat_nxt = status_rd ? live : stat_r;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drv_r  <= {2{amd_pkg::AMD_DRV_TRISTATE}};
      off_r  <= '0;
      nlow_r <= '0;
      stat_r <= '0;
    end else begin
      drv_r  <= drv_nxt;
      off_r  <= off_nxt;
      nlow_r <= nlow_nxt;
      stat_r <= stat_nxt;
    end
  end

  assign ctl_q               = ctl_r;
  assign status_q            = stat_r;
  assign wr_addr             = addr_r;
  assign pwr_state           = pwr_r;
  assign charge_pump_on      = (pwr_r == amd_pkg::AMD_PWR_ACTIVE);
  assign input_charge_on     = ctl_r.input_charge_en & charge_pump_on;
  assign short_thresh_raised = ~ctl_r.short_threshold_sel;
  assign load_thresh_200     = ctl_r.load_threshold_sel;
  assign drain_on            = ctl_r.output_drain_to_ground;
  assign pair_drive          = drv_r;
  assign neg_low_side_on     = nlow_r;
  assign ch_latched_off      = off_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  addr_pin_a: assert property (
    ##1 ctl_r.addr_default_flag
    |=> addr_r == (`AMD_ADDR_BASE | {5'h00, 1'b0, $past(lsb_r), 1'b0}))
    else $error("default address does not follow the pin");

  addr_sel_a: assert property (
    !ctl_r.addr_default_flag |=> addr_r == (`AMD_ADDR_BASE | {5'h00, $past(ctl_r.addr_sel), 1'b0}))
    else $error("selected address wrong");

  write_apply_a: assert property (
    en_pin && ctl_wr_done |=> ctl_r == $past(ctl_wdata))
    else $error("write not applied");

  standby_pwr_a: assert property (
    en_pin && ctl_r.standby_ctl |=> pwr_r == amd_pkg::AMD_PWR_STANDBY && !charge_pump_on)
    else $error("standby not entered");

  precharge_mode_a: assert property (
    pwr_r == amd_pkg::AMD_PWR_ACTIVE && !diag_busy
    && ctl_r.ch01_output_mode == `AMD_MODE_PRECHARGE
    |=> pair_drive[0] == amd_pkg::AMD_DRV_PRECHARGE)
    else $error("precharge not driven");

  play_mode_a: assert property (
    pwr_r == amd_pkg::AMD_PWR_ACTIVE && !diag_busy
    && ctl_r.ch23_output_mode == `AMD_MODE_PLAY |=> pair_drive[1] == amd_pkg::AMD_DRV_PLAY)
    else $error("play not driven");

  short_live_a: assert property (
    status_rd && !ctl_r.short_diag_en |=> status_q.short_batt_flags == 4'h0
    && status_q.short_ground_flags == 4'h0)
    else $error("short flags set with diagnostic off");

  short_split_a: assert property (
    status_rd && ctl_r.short_diag_en |=> status_q.short_batt_flags == $past(out_above_ref)
    && status_q.short_ground_flags == ~$past(out_above_ref))
    else $error("short flags disagree with reference");

  open_switch_a: assert property (
    ctl_r.open_load_diag_en |=> neg_low_side_on == 4'hF
    && pair_drive == {2{amd_pkg::AMD_DRV_TRISTATE}})
    else $error("open-load switch pattern wrong");

  oc_latch_a: assert property (
    pwr_r == amd_pkg::AMD_PWR_ACTIVE
    |=> (ch_latched_off & $past(ch_latched_off)) == $past(ch_latched_off))
    else $error("overcurrent latch released while active");

endmodule

//--- src/amd_pkg.sv
// Types shared by the amplifier control and load diagnostic block
package amd_pkg;

  // ----------------------------------------------------------------
  // Control fields as written by the host
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       addr_default_flag;
    logic [1:0] addr_sel;
    logic       short_threshold_sel;
    logic       standby_ctl;
    logic       input_charge_en;
    logic [1:0] ch01_output_mode;
    logic [1:0] ch23_output_mode;
    logic       short_diag_en;
    logic       output_drain_to_ground;
    logic       open_load_diag_en;
    logic       load_threshold_sel;
  } amd_ctl_type;

  // ----------------------------------------------------------------
  // Status flags as sampled for a read
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] short_batt_flags;
    logic [3:0] short_ground_flags;
    logic [3:0] load_ok_flags;
    logic [3:0] overcurrent_flags;
  } amd_status_type;

  typedef enum logic [1:0] {
    AMD_PWR_OFF,
    AMD_PWR_STANDBY,
    AMD_PWR_ACTIVE
  } amd_pwr_type;

  typedef enum logic [1:0] {
    AMD_DRV_TRISTATE,
    AMD_DRV_MUTE,
    AMD_DRV_PRECHARGE,
    AMD_DRV_PLAY
  } amd_drive_type;

endpackage

//--- src/amd_regs.svh
// Reset values, address codes and mode encodings of the amplifier control block
`ifndef AMD_REGS_SVH
`define AMD_REGS_SVH

// ----------------------------------------------------------------
// Target address
// ----------------------------------------------------------------
`define AMD_ADDR_BASE        8'hD8
`define AMD_ADDR_IDX_LSB     1

// ----------------------------------------------------------------
// Channel-pair output mode field codes
// ----------------------------------------------------------------
`define AMD_MODE_TRISTATE    2'h0
`define AMD_MODE_MUTE        2'h1
`define AMD_MODE_PRECHARGE   2'h2
`define AMD_MODE_PLAY        2'h3

// ----------------------------------------------------------------
// Control field reset values
// ----------------------------------------------------------------
`define AMD_RST_ADDR_DEFAULT 1'h1
`define AMD_RST_ADDR_SEL     2'h0
`define AMD_RST_SHORT_THR    1'h1
`define AMD_RST_STANDBY      1'h1
`define AMD_RST_CHARGE       1'h0
`define AMD_RST_MODE         2'h0
`define AMD_RST_DIAG         1'h0
`define AMD_RST_LOAD_THR     1'h0

`endif
